// >>> shared/rx_timeout_pkg.sv
package rx_timeout_pkg;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	// printed index of the config register; byte address is four times it
	localparam logic [15:0] RX_CFG_INDEX = 16'hdf12;
	// status register index, next free word above the radio block
	localparam logic [15:0] RX_STATUS_INDEX = 16'hdf80;
	localparam logic [31:0] RX_CFG_ADDR = {14'h0000, RX_CFG_INDEX, 2'b00};
	localparam logic [31:0] RX_STATUS_ADDR = {14'h0000, RX_STATUS_INDEX, 2'b00};

	// ------------------------------------------------------------
	// config fields and reset value
	// ------------------------------------------------------------
	localparam int CFG_END_ON_CS_BIT = 4;
	localparam int CFG_QUAL_BIT = 3;
	localparam int CFG_SEL_MSB = 2;
	localparam int CFG_WIDTH = 5;
	localparam logic [7:0] RX_CFG_RESET = 8'h07;
	// select code that turns the timeout off
	localparam logic [2:0] SEL_NO_TIMEOUT = 3'h7;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	// coefficient times 26 times 4, per wake resolution, in reference ticks
	localparam logic [15:0] COEF_RES0 = 16'h0177;
	localparam logic [15:0] COEF_RES1 = 16'h0753;
	localparam logic [15:0] COEF_RES2 = 16'h0d2f;
	localparam logic [15:0] COEF_RES3 = 16'h130b;
	// the x4 scaling above is undone by two extra shift steps
	localparam int COEF_SCALE_SHIFT = 2;
	localparam int REF_MHZ_DEFAULT = 26;
	localparam int CLK_MHZ = 250;
	localparam int LIMIT_WIDTH = 32;

	// status bit positions
	localparam int ST_RUNNING_BIT = 0;
	localparam int ST_EXPIRED_BIT = 1;
	localparam int ST_SYNC_BIT = 2;
	localparam int ST_PQT_BIT = 3;
	localparam int ST_END_TIMEOUT_BIT = 4;
	localparam int ST_END_CS_BIT = 5;

endpackage : rx_timeout_pkg

// >>> shared/rx_timer_if.sv
// carries the timeout request from control to the timer and the expiry back
interface rx_timer_if;
	import rx_timeout_pkg::*;
	logic start; // one-cycle pulse, restarts the count
	logic stop; // one-cycle pulse, abandons the count
	logic [LIMIT_WIDTH-1:0] limit; // reference ticks to wait, held from start
	logic expired; // one-cycle pulse when the limit is reached

	modport ctrl (output start, output stop, output limit, input expired);
	modport timer (input start, input stop, input limit, output expired);
endinterface : rx_timer_if

// >>> core/rx_sync_timer.sv
module rx_sync_timer
	import rx_timeout_pkg::*;
#(
	parameter int REF_MHZ = REF_MHZ_DEFAULT
)
(
	input wire logic pclk,
	input wire logic presetn,
	rx_timer_if.timer tmr
);

	// ------------------------------------------------------------
	// reference tick and count state
	// ------------------------------------------------------------
	logic [8:0] acc; // fractional phase of the reference clock
	logic [8:0] next_acc;
	logic [LIMIT_WIDTH-1:0] count; // reference ticks seen since start
	logic [LIMIT_WIDTH-1:0] next_count;
	logic running;
	logic next_running;
	logic expired;
	logic next_expired;
	logic [8:0] sum;

	assign tmr.expired = expired;

	// reference ticks are made by phase accumulation, so a 26 MHz
	// reference is honoured on average without a second clock domain
	always_comb
	begin
		sum = acc + 9'(REF_MHZ);
		next_acc = acc;
		next_count = count;
		next_running = running;
		next_expired = 1'b0;
		if (tmr.start)
		begin
			// restart phase too, so every timeout starts from a clean tick
			next_acc = '0;
			next_count = '0;
			next_running = 1'b1;
		end
		else if (tmr.stop)
		begin
			next_running = 1'b0;
		end
		else if (running)
		begin
			if (sum >= 9'(CLK_MHZ))
			begin
				// one reference period has passed
				next_acc = sum - 9'(CLK_MHZ);
				if (count + 1'b1 >= tmr.limit)
				begin
					next_expired = 1'b1;
					next_running = 1'b0;
				end
				next_count = count + 1'b1;
			end
			else
			begin
				next_acc = sum;
			end
		end
	end

	// registers only
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc <= '0;
			count <= '0;
			running <= 1'b0;
			expired <= 1'b0;
		end
		else
		begin
			acc <= next_acc;
			count <= next_count;
			running <= next_running;
			expired <= next_expired;
		end
	end

endmodule : rx_sync_timer

// >>> core/radio_rx_sync_timeout.sv
// Local design decision: the APB interface to the registers.
module radio_rx_sync_timeout
	import rx_timeout_pkg::*;
#(
	parameter int REF_MHZ = REF_MHZ_DEFAULT
)
(
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// radio side, same clock
	input wire logic rx_active,
	input wire logic sync_detected,
	input wire logic pqt_reached,
	input wire logic carrier_sense,
	input wire logic [15:0] wake_event_period,
	input wire logic [1:0] wake_timer_resolution,
	output logic rx_end
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	rx_timer_if tmr (); // link to the tick counter

	logic [CFG_WIDTH-1:0] cfg; // stored config bits 4:0
	logic [CFG_WIDTH-1:0] next_cfg;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic rx_active_q; // previous receive level, for start edge
	logic next_rx_active_q;
	logic sync_seen; // sync found in this receive
	logic next_sync_seen;
	logic pqt_seen; // preamble quality reached in this receive
	logic next_pqt_seen;
	logic timer_running; // a timeout is pending
	logic next_timer_running;
	logic expired_flag; // last receive saw the timer expire
	logic next_expired_flag;
	logic end_by_timeout; // last end came from the timer
	logic next_end_by_timeout;
	logic end_by_cs; // last end came from carrier sense
	logic next_end_by_cs;
	logic next_rx_end;
	logic start_pulse;
	logic next_start_pulse;
	logic stop_pulse;
	logic next_stop_pulse;
	logic [LIMIT_WIDTH-1:0] limit;
	logic [LIMIT_WIDTH-1:0] next_limit;

	logic [2:0] sel;
	logic end_on_cs;
	logic qual;

	assign sel = cfg[CFG_SEL_MSB:0];
	assign end_on_cs = cfg[CFG_END_ON_CS_BIT];
	assign qual = cfg[CFG_QUAL_BIT];

	assign tmr.start = start_pulse;
	assign tmr.stop = stop_pulse;
	assign tmr.limit = limit;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// coefficient times 26 times 4 for the resolution at select zero
	function automatic logic [15:0] coef_of(input logic [1:0] res);
		logic [15:0] c;
		unique case (res)
			2'd0: c = COEF_RES0;
			2'd1: c = COEF_RES1;
			2'd2: c = COEF_RES2;
			2'd3: c = COEF_RES3;
		endcase
		return c;
	endfunction : coef_of

	// reference ticks to wait; each select step halves the coefficient
	function automatic logic [LIMIT_WIDTH-1:0] ticks_of(
		input logic [15:0] period,
		input logic [1:0] res,
		input logic [2:0] s
	);
		logic [LIMIT_WIDTH-1:0] prod;
		prod = LIMIT_WIDTH'(period) * LIMIT_WIDTH'(coef_of(res));
		return prod >> (32'(s) + COEF_SCALE_SHIFT);
	endfunction : ticks_of

	// register decode
	function automatic logic is_cfg(input logic [31:0] a);
		return a == RX_CFG_ADDR;
	endfunction : is_cfg

	function automatic logic is_status(input logic [31:0] a);
		return a == RX_STATUS_ADDR;
	endfunction : is_status

	// ------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------
	// no wait state: read data and answer are set up in the setup
	// cycle so every output comes from a flop
	always_comb
	begin
		next_cfg = cfg;
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (psel && !penable)
		begin
			// setup phase: prepare the answer for the access phase
			next_pready = 1'b1;
			next_pslverr = !(is_cfg(paddr) || is_status(paddr));
			next_prdata = '0;
			if (is_cfg(paddr))
			begin
				next_prdata = {27'h000_0000, cfg};
			end
			else if (is_status(paddr))
			begin
				next_prdata[ST_RUNNING_BIT] = timer_running;
				next_prdata[ST_EXPIRED_BIT] = expired_flag;
				next_prdata[ST_SYNC_BIT] = sync_seen;
				next_prdata[ST_PQT_BIT] = pqt_seen;
				next_prdata[ST_END_TIMEOUT_BIT] = end_by_timeout;
				next_prdata[ST_END_CS_BIT] = end_by_cs;
			end
		end
		else if (psel && penable && pready)
		begin
			// access completes here; writes take effect on this edge
			if (pwrite && is_cfg(paddr))
			begin
				next_cfg = pwdata[CFG_WIDTH-1:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg <= RX_CFG_RESET[CFG_WIDTH-1:0];
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			cfg <= next_cfg;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ------------------------------------------------------------
	// receive control
	// ------------------------------------------------------------
	// the limit is latched at receive start, so a select write during
	// receive only affects the next one
	always_comb
	begin
		next_rx_active_q = rx_active;
		next_sync_seen = sync_seen;
		next_pqt_seen = pqt_seen;
		next_timer_running = timer_running;
		next_expired_flag = expired_flag;
		next_end_by_timeout = end_by_timeout;
		next_end_by_cs = end_by_cs;
		next_rx_end = 1'b0;
		next_start_pulse = 1'b0;
		next_stop_pulse = 1'b0;
		next_limit = limit;
		if (rx_active && !rx_active_q)
		begin
			// new receive: clear history and arm the timer unless disabled
			next_sync_seen = sync_detected;
			next_pqt_seen = pqt_reached;
			next_expired_flag = 1'b0;
			next_end_by_timeout = 1'b0;
			next_end_by_cs = 1'b0;
			if (sel != SEL_NO_TIMEOUT)
			begin
				next_limit = ticks_of(wake_event_period, wake_timer_resolution, sel);
				next_start_pulse = 1'b1;
				next_timer_running = 1'b1;
			end
		end
		else if (rx_active)
		begin
			// detector events are sticky for the whole receive
			next_sync_seen = sync_seen || sync_detected;
			next_pqt_seen = pqt_seen || pqt_reached;
			if (end_on_cs && !carrier_sense && !rx_end)
			begin
				// carrier gone: end at once, drop any pending timeout
				next_rx_end = 1'b1;
				next_end_by_cs = 1'b1;
				next_stop_pulse = timer_running;
				next_timer_running = 1'b0;
			end
			else if (timer_running && tmr.expired)
			begin
				next_timer_running = 1'b0;
				next_expired_flag = 1'b1;
				// a detection in the expiry cycle still counts
				if (!(sync_seen || sync_detected) && !qual)
				begin
					next_rx_end = 1'b1;
					next_end_by_timeout = 1'b1;
				end
				else if (!(sync_seen || sync_detected || pqt_seen || pqt_reached))
				begin
					next_rx_end = 1'b1;
					next_end_by_timeout = 1'b1;
				end
			end
		end
		else if (timer_running)
		begin
			// receive left by other means: abandon the timeout
			next_stop_pulse = 1'b1;
			next_timer_running = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rx_active_q <= 1'b0;
			sync_seen <= 1'b0;
			pqt_seen <= 1'b0;
			timer_running <= 1'b0;
			expired_flag <= 1'b0;
			end_by_timeout <= 1'b0;
			end_by_cs <= 1'b0;
			rx_end <= 1'b0;
			start_pulse <= 1'b0;
			stop_pulse <= 1'b0;
			limit <= '0;
		end
		else
		begin
			rx_active_q <= next_rx_active_q;
			sync_seen <= next_sync_seen;
			pqt_seen <= next_pqt_seen;
			timer_running <= next_timer_running;
			expired_flag <= next_expired_flag;
			end_by_timeout <= next_end_by_timeout;
			end_by_cs <= next_end_by_cs;
			rx_end <= next_rx_end;
			start_pulse <= next_start_pulse;
			stop_pulse <= next_stop_pulse;
			limit <= next_limit;
		end
	end

	// ------------------------------------------------------------
	// tick counter
	// ------------------------------------------------------------
	rx_sync_timer #(
		.REF_MHZ(REF_MHZ)
	) u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.tmr(tmr)
	);

endmodule : radio_rx_sync_timeout

// >>> verification/rx_timeout_asserts.sv
// ----------------------------------------
// port checker for the receive timeout block
// ----------------------------------------
module rx_timeout_chk
	import rx_timeout_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic rx_active,
	input wire logic carrier_sense,
	input wire logic rx_end
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic [4:0] cfg; // shadow of the writable config bits
	logic [4:0] next_cfg;
	logic wr_cfg; // completed write to the config word
	logic rx_active_q; // receive level one cycle ago, as the design keeps it
	logic [2:0] rx_sel; // select in force for the current receive
	logic [2:0] next_rx_sel;
	assign wr_cfg = psel && penable && pready && pwrite && paddr == RX_CFG_ADDR;
	// shadow follows completed writes only
	always_comb
	begin
		next_cfg = cfg;
		next_rx_sel = rx_sel;
		if (wr_cfg)
			next_cfg = pwdata[4:0];
		// a select write during receive only counts for the next one
		if (rx_active && !rx_active_q)
			next_rx_sel = cfg[2:0];
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cfg <= RX_CFG_RESET[4:0];
			rx_active_q <= 1'b0;
			rx_sel <= SEL_NO_TIMEOUT;
		end
		else
		begin
			cfg <= next_cfg;
			rx_active_q <= rx_active;
			rx_sel <= next_rx_sel;
		end
	end
	// ----------------------------------------
	// bus and register
	// ----------------------------------------
	setup_answer_a: assert property (psel && !penable |=> pready)
		else $error("no answer after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	unmapped_err_a: assert property (pready && paddr != RX_CFG_ADDR && paddr != RX_STATUS_ADDR
		|-> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	cfg_read_a: assert property (pready && !pwrite && paddr == RX_CFG_ADDR
		|-> !pslverr && prdata == {27'h000_0000, cfg})
		else $error("config read mismatch");
	// ----------------------------------------
	// receive end
	// ----------------------------------------
	end_pulse_a: assert property (rx_end |=> !rx_end)
		else $error("rx_end longer than one cycle");
	// the start cycle itself only arms the receive, carrier is judged from the next one
	cs_end_a: assert property (cfg[4] && rx_active && rx_active_q && !carrier_sense
		&& !rx_end |=> rx_end)
		else $error("carrier loss did not end receive");
	end_in_rx_a: assert property (rx_end |-> $past(rx_active))
		else $error("rx_end outside receive");
	no_timeout_a: assert property (rx_end |-> rx_sel != SEL_NO_TIMEOUT
		|| $past(cfg[4] && !carrier_sense))
		else $error("timeout with select off");
	cfg_write_c: cover property (wr_cfg);
	rx_end_c: cover property (rx_end);
	refused_c: cover property (pready && pslverr);
endmodule : rx_timeout_chk

bind radio_rx_sync_timeout rx_timeout_chk chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .rx_active, .carrier_sense, .rx_end);

// >>> verification/testbench.sv
// ----------------------------------------
// self-checking bench, ticks run at clock rate
// ----------------------------------------
module testbench
	import rx_timeout_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic rx_active = 0;
	logic sync_detected = 0;
	logic pqt_reached = 0;
	logic carrier_sense = 1;
	logic [15:0] wake_event_period = 16'h0001;
	logic [1:0] wake_timer_resolution = 2'h0;
	logic rx_end;
	logic [31:0] rdat; // read data taken at completion
	logic rerr; // error flag taken at completion
	logic [15:0] lfsr = 16'ha96a; // 43370
	logic [31:0] wd;
	int errors = 0;
	int num_checks = 0;
	int kt [4] = '{375, 1875, 3375, 4875}; // coefficient times 104
	int exp_q [$]; // model: expected end cycle of each receive
	always #2 pclk = ~pclk;
	// ref rate equals clock rate so one tick per cycle keeps limits short
	radio_rx_sync_timeout #(.REF_MHZ(250)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rx_active(rx_active),
		.sync_detected(sync_detected), .pqt_reached(pqt_reached), .carrier_sense(carrier_sense),
		.wake_event_period(wake_event_period), .wake_timer_resolution(wake_timer_resolution),
		.rx_end(rx_end));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : nxt
	task summarize;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : summarize
	task check(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	// one apb transfer; answer taken at the rising edge that sees pready
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	// one receive: config, resolution, sync, quality, carrier lost
	task rx(input logic [4:0] c, input logic [1:0] r, input logic s, input logic q,
		input logic k);
		int lim;
		int n;
		logic keep;
		lfsr = nxt(lfsr);
		lim = ((1 + lfsr[0]) * kt[r]) >> (c[2:0] + 2);
		keep = c[2:0] == SEL_NO_TIMEOUT || s || (c[3] && q);
		exp_q.push_back(lim);
		apb(1'b1, RX_CFG_ADDR, {27'h000_0000, c});
		@(posedge pclk);
		wake_event_period <= 16'h0001 + lfsr[0];
		wake_timer_resolution <= r;
		sync_detected <= s;
		pqt_reached <= q;
		carrier_sense <= !k;
		rx_active <= 1;
		n = -1;
		do
		begin
			@(negedge pclk);
			n++;
		end
		while (rx_end !== 1'b1 && n < lim + 40);
		lim = exp_q.pop_front();
		if (k && c[4])
			check("cs end", 32'h0000_0001, {31'h0, n <= 3});
		else if (keep)
			check("kept", 32'h0000_0001, {31'h0, n >= lim + 40});
		else
			check("timeout", 32'h0000_0001, {31'h0, n >= lim && n <= lim + 8});
		@(posedge pclk);
		rx_active <= 0;
		sync_detected <= 0;
		pqt_reached <= 0;
		carrier_sense <= 1;
		repeat (3) @(posedge pclk);
	endtask : rx
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1;
		apb(1'b0, RX_CFG_ADDR, 32'h0000_0000);
		check("cfg reset", {24'h00_0000, RX_CFG_RESET}, rdat);
		lfsr = nxt(lfsr);
		wd = {lfsr, ~lfsr};
		apb(1'b1, RX_CFG_ADDR, wd);
		apb(1'b0, RX_CFG_ADDR, 32'h0000_0000);
		check("cfg upper", {27'h000_0000, wd[4:0]}, rdat);
		apb(1'b0, RX_CFG_ADDR + 32'h0000_0004, 32'h0000_0000);
		check("unmapped err", 32'h0000_0001, {31'h0, rerr});
		check("unmapped data", 32'h0000_0000, rdat);
		$display("test apb done");
		// every select with every resolution, no sync found
		for (int r = 0; r < 4; r++)
			for (int s = 0; s < 8; s++)
				rx({2'b00, s[2:0]}, r[1:0], 1'b0, 1'b0, 1'b0);
		$display("test timeout done");
		rx(5'h06, 2'h0, 1'b1, 1'b0, 1'b0);
		rx(5'h06, 2'h0, 1'b0, 1'b1, 1'b0);
		rx(5'h0e, 2'h1, 1'b0, 1'b1, 1'b0);
		rx(5'h0e, 2'h0, 1'b1, 1'b0, 1'b0);
		rx(5'h0e, 2'h0, 1'b0, 1'b0, 1'b0);
		// status keeps the history of the last receive: expired, ended by timeout
		apb(1'b0, RX_STATUS_ADDR, 32'h0000_0000);
		check("status timeout", 32'h0000_0012, rdat);
		$display("test qualifier done");
		rx(5'h17, 2'h0, 1'b0, 1'b0, 1'b1);
		rx(5'h07, 2'h0, 1'b0, 1'b0, 1'b1);
		rx(5'h16, 2'h2, 1'b0, 1'b0, 1'b1);
		// carrier end abandons the timer and is recorded as such
		apb(1'b0, RX_STATUS_ADDR, 32'h0000_0000);
		check("status carrier", 32'h0000_0020, rdat);
		$display("test carrier done");
		summarize;
	end
	// hang guard, a few times the longest timeout sweep
	initial
	begin
		#160000;
		errors++;
		$display("ERROR watchdog expected done seen hang");
		summarize;
	end
endmodule : testbench
